/* design/tofo_pkg.sv */
// Purpose: shared constants of the temperature correction and alarm-to-fan override registers
// Assumes: byte-wide register port fed by the management bus slave on the same clock
// Notes: temperatures are signed fixed point, 1/8 degree per lsb
package tofo_pkg;

   // register addresses on the internal register port
   localparam logic [7:0] ADDR_LOCAL_CORR = 8'h0d;   // local_temp_correction
   localparam logic [7:0] ADDR_REMOTE_CORR = 8'h0e;  // remote_temp_correction
   localparam logic [7:0] ADDR_OVR_REV = 8'h3f;      // alarm_fan_override_and_revision

   // reset values and the unmapped read value
   localparam logic [7:0] RST_LOCAL_CORR = 8'h00;
   localparam logic [7:0] RST_REMOTE_CORR = 8'h00;
   localparam logic RST_FAN_FORCE_EN = 1'b1;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // override/revision field layout
   localparam int OVR_FORCE_BIT = 7;
   localparam int OVR_ZERO_HI = 6;
   localparam int OVR_ZERO_LO = 4;
   localparam int OVR_REV_HI = 3;
   localparam int OVR_REV_LO = 0;

   // correction register field layout
   localparam int CORR_SIGN_BIT = 7;
   localparam int CORR_SPARE_HI = 6;
   localparam int CORR_SPARE_LO = 4;
   localparam int CORR_MAG_HI = 3;
   localparam int CORR_MAG_LO = 0;
   localparam int CORR_MAG_W = 4;

   // silicon revision nibble, value is arbitrary
   localparam logic [3:0] SILICON_REVISION = 4'h1;

   // temperature number format
   localparam int TEMP_W = 11;       // signed, whole degrees in the upper bits
   localparam int TEMP_FRAC = 3;     // fractional bits, 0.125 degree resolution
   localparam logic signed [TEMP_W-1:0] TEMP_MAX = 11'sh3ff;
   localparam logic signed [TEMP_W-1:0] TEMP_MIN = 11'sh400;

   // fan duty field and its full speed code
   localparam int DUTY_W = 4;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 4'hf;
   localparam logic [DUTY_W-1:0] RST_DUTY = 4'h0;

endpackage

/* design/tofo_offset_apply.sv */
// Purpose: applies a sign/magnitude correction to one temperature reading
// Assumes: reading is signed fixed point with tofo_pkg::TEMP_FRAC fraction bits
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module tofo_offset_apply (
   // reading and correction register
   input wire logic signed [tofo_pkg::TEMP_W-1:0] raw_i,
   input wire logic [7:0] corr_reg_i,
   // corrected reading
   output logic signed [tofo_pkg::TEMP_W-1:0] corrected_o
);

   // one extra bit so the sum can be checked for overflow before clamping
   logic signed [tofo_pkg::TEMP_W:0] offset_scaled;
   logic signed [tofo_pkg::TEMP_W:0] sum_wide;
   logic [tofo_pkg::CORR_MAG_W-1:0] magnitude;

   //////////////////////////////////////////////////////////////////////////////
   // add or subtract the whole-degree offset, clamping to the number range
   always_comb begin
      magnitude = corr_reg_i[tofo_pkg::CORR_MAG_HI:tofo_pkg::CORR_MAG_LO];
      // whole degrees move up by the fraction width; bits 6:4 play no part
      offset_scaled = $signed({{(tofo_pkg::TEMP_W+1-tofo_pkg::CORR_MAG_W-tofo_pkg::TEMP_FRAC){1'b0}},
                               magnitude, {tofo_pkg::TEMP_FRAC{1'b0}}});
      if (corr_reg_i[tofo_pkg::CORR_SIGN_BIT]) begin
         // sign set: subtract
         sum_wide = {raw_i[tofo_pkg::TEMP_W-1], raw_i} - offset_scaled;
      end else begin
         // sign clear: add
         sum_wide = {raw_i[tofo_pkg::TEMP_W-1], raw_i} + offset_scaled;
      end
      // clamp rather than wrap, a wrapped hot reading would look cold
      if (sum_wide > $signed({tofo_pkg::TEMP_MAX[tofo_pkg::TEMP_W-1], tofo_pkg::TEMP_MAX})) begin
         corrected_o = tofo_pkg::TEMP_MAX;
      end else if (sum_wide < $signed({tofo_pkg::TEMP_MIN[tofo_pkg::TEMP_W-1], tofo_pkg::TEMP_MIN})) begin
         corrected_o = tofo_pkg::TEMP_MIN;
      end else begin
         corrected_o = sum_wide[tofo_pkg::TEMP_W-1:0];
      end
   end

endmodule

`default_nettype wire

/* design/tofo_regs.sv */
// Purpose: temperature correction registers and the alarm-to-fan override register
// Assumes: register port comes from the management bus slave, same clock, one access per strobe
// Notes: all outputs are registered; read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module tofo_regs (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port from the bus slave
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // raw readings from the measurement path
   input wire logic signed [tofo_pkg::TEMP_W-1:0] local_temp_raw_i,
   input wire logic signed [tofo_pkg::TEMP_W-1:0] remote_temp_raw_i,
   // corrected readings to fan loop, limit compare and readback
   output logic signed [tofo_pkg::TEMP_W-1:0] local_temp_corr_o,
   output logic signed [tofo_pkg::TEMP_W-1:0] remote_temp_corr_o,
   // thermal alarm: own drive request and the sensed pin level
   input wire logic alarm_drive_i,
   input wire logic alarm_pin_i,
   // fan stage
   input wire logic [tofo_pkg::DUTY_W-1:0] fan_duty_cmd_i,
   output logic [tofo_pkg::DUTY_W-1:0] fan_duty_o,
   output logic fan_full_speed_o,
   output logic alarm_ext_pull_o
);

   //////////////////////////////////////////////////////////////////////////////
   // storage

   logic [7:0] local_corr_reg;          // whole local correction byte, spare bits kept
   logic [7:0] local_corr_next;
   logic [7:0] remote_corr_reg;         // whole remote correction byte, spare bits kept
   logic [7:0] remote_corr_next;
   logic overtemp_fan_force_en_reg;     // only writable bit of the override register
   logic overtemp_fan_force_en_next;
   logic [7:0] rdata_reg;               // read data holding register
   logic [7:0] rdata_next;

   // pin synchroniser, first stage read only by the second
   logic alarm_pin_meta_reg;
   logic alarm_pin_sync_reg;

   // output stage
   logic signed [tofo_pkg::TEMP_W-1:0] local_corr_out_reg;
   logic signed [tofo_pkg::TEMP_W-1:0] local_corr_out_next;
   logic signed [tofo_pkg::TEMP_W-1:0] remote_corr_out_reg;
   logic signed [tofo_pkg::TEMP_W-1:0] remote_corr_out_next;
   logic [tofo_pkg::DUTY_W-1:0] duty_reg;
   logic [tofo_pkg::DUTY_W-1:0] duty_next;
   logic full_speed_reg;
   logic full_speed_next;
   logic ext_pull_reg;
   logic ext_pull_next;

   // combinational results of the two correction paths
   logic signed [tofo_pkg::TEMP_W-1:0] local_adjusted;
   logic signed [tofo_pkg::TEMP_W-1:0] remote_adjusted;

   //////////////////////////////////////////////////////////////////////////////
   // helpers

   // address match, used by the write decode; the read decode uses a case
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction

   // readback image of the override register
   function automatic logic [7:0] ovr_image(input logic force_en);
      logic [7:0] img;
      img = 8'h00;
      img[tofo_pkg::OVR_FORCE_BIT] = force_en;
      img[tofo_pkg::OVR_REV_HI:tofo_pkg::OVR_REV_LO] = tofo_pkg::SILICON_REVISION;
      ovr_image = img;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // correction datapaths

   // local reading correction
   tofo_offset_apply u_local_apply (
      .raw_i(local_temp_raw_i),
      .corr_reg_i(local_corr_reg),
      .corrected_o(local_adjusted)
   );

   // remote reading correction
   tofo_offset_apply u_remote_apply (
      .raw_i(remote_temp_raw_i),
      .corr_reg_i(remote_corr_reg),
      .corrected_o(remote_adjusted)
   );

   //////////////////////////////////////////////////////////////////////////////
   // register writes

   // next values of the software-visible storage
   always_comb begin
      local_corr_next = local_corr_reg;
      remote_corr_next = remote_corr_reg;
      overtemp_fan_force_en_next = overtemp_fan_force_en_reg;
      if (reg_wr_i) begin
         if (addr_hit(reg_addr_i, tofo_pkg::ADDR_LOCAL_CORR)) begin
            // full byte is stored, spare bits included
            local_corr_next = reg_wdata_i;
         end else if (addr_hit(reg_addr_i, tofo_pkg::ADDR_REMOTE_CORR)) begin
            remote_corr_next = reg_wdata_i;
         end else if (addr_hit(reg_addr_i, tofo_pkg::ADDR_OVR_REV)) begin
            // revision and zero bits are not stored, so writes cannot touch them
            overtemp_fan_force_en_next = reg_wdata_i[tofo_pkg::OVR_FORCE_BIT];
         end else begin
            // unmapped address: write is dropped
            local_corr_next = local_corr_reg;
         end
      end
   end

   // register the storage
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         local_corr_reg <= tofo_pkg::RST_LOCAL_CORR;
         remote_corr_reg <= tofo_pkg::RST_REMOTE_CORR;
         overtemp_fan_force_en_reg <= tofo_pkg::RST_FAN_FORCE_EN;
      end else begin
         local_corr_reg <= local_corr_next;
         remote_corr_reg <= remote_corr_next;
         overtemp_fan_force_en_reg <= overtemp_fan_force_en_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // register reads

   // read mux; the data holds until the next read strobe
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         case (reg_addr_i)
            tofo_pkg::ADDR_LOCAL_CORR: begin
               rdata_next = local_corr_reg;
            end
            tofo_pkg::ADDR_REMOTE_CORR: begin
               rdata_next = remote_corr_reg;
            end
            tofo_pkg::ADDR_OVR_REV: begin
               rdata_next = ovr_image(overtemp_fan_force_en_reg);
            end
            default: begin
               // unmapped addresses answer with a fixed value
               rdata_next = tofo_pkg::RDATA_UNMAPPED;
            end
         endcase
      end
   end

   // register the read data
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // alarm pin synchroniser

   // the pin is driven by us and possibly by other parts, so it is asynchronous
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_pin_meta_reg <= 1'b1;
         alarm_pin_sync_reg <= 1'b1;
      end else begin
         alarm_pin_meta_reg <= alarm_pin_i;
         alarm_pin_sync_reg <= alarm_pin_meta_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // fan override and corrected outputs

   // fan forcing only listens to our own alarm request, never the pin level
   always_comb begin
      full_speed_next = overtemp_fan_force_en_reg & alarm_drive_i;
      if (full_speed_next) begin
         duty_next = tofo_pkg::DUTY_FULL;
      end else begin
         // silent mode or no alarm: pass the commanded speed
         duty_next = fan_duty_cmd_i;
      end
      // pin low while we are not driving it means someone else pulls it
      ext_pull_next = ~alarm_pin_sync_reg & ~alarm_drive_i;
      // corrected values are the only temperatures handed onward
      local_corr_out_next = local_adjusted;
      remote_corr_out_next = remote_adjusted;
   end

   // register every output
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full_speed_reg <= 1'b0;
         duty_reg <= tofo_pkg::RST_DUTY;
         ext_pull_reg <= 1'b0;
         local_corr_out_reg <= '0;
         remote_corr_out_reg <= '0;
      end else begin
         full_speed_reg <= full_speed_next;
         duty_reg <= duty_next;
         ext_pull_reg <= ext_pull_next;
         local_corr_out_reg <= local_corr_out_next;
         remote_corr_out_reg <= remote_corr_out_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // ports

   assign reg_rdata_o = rdata_reg;
   assign fan_full_speed_o = full_speed_reg;
   assign fan_duty_o = duty_reg;
   assign alarm_ext_pull_o = ext_pull_reg;
   assign local_temp_corr_o = local_corr_out_reg;
   assign remote_temp_corr_o = remote_corr_out_reg;

endmodule

`default_nettype wire

/* verif/tofo_checker.sv */
// Purpose: port-level checks of the correction and alarm-to-fan override registers
// Assumes: one clock domain, mirrors of the stored bytes follow writes at the design's own edge
// Notes: read data and fan outputs are registered, hence the one-cycle implications
`timescale 1ns/1ps
`default_nettype none

module tofo_checker (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // readings, alarm and fan
   input wire logic signed [tofo_pkg::TEMP_W-1:0] local_temp_raw_i,
   input wire logic signed [tofo_pkg::TEMP_W-1:0] remote_temp_raw_i,
   input wire logic signed [tofo_pkg::TEMP_W-1:0] local_temp_corr_o,
   input wire logic signed [tofo_pkg::TEMP_W-1:0] remote_temp_corr_o,
   input wire logic alarm_drive_i,
   input wire logic alarm_pin_i,
   input wire logic [tofo_pkg::DUTY_W-1:0] fan_duty_cmd_i,
   input wire logic [tofo_pkg::DUTY_W-1:0] fan_duty_o,
   input wire logic fan_full_speed_o,
   input wire logic alarm_ext_pull_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] loc_reg, loc_next, rem_reg, rem_next; // mirrored correction bytes
   logic frc_reg, frc_next; // mirrored force bit

   // mirror next values, only the force bit of the override byte is writable
   always_comb begin
      loc_next = (reg_wr_i && reg_addr_i == tofo_pkg::ADDR_LOCAL_CORR) ? reg_wdata_i : loc_reg;
      rem_next = (reg_wr_i && reg_addr_i == tofo_pkg::ADDR_REMOTE_CORR) ? reg_wdata_i : rem_reg;
      frc_next = (reg_wr_i && reg_addr_i == tofo_pkg::ADDR_OVR_REV) ? reg_wdata_i[7] : frc_reg;
   end

   // mirror registers with the documented power-up values
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loc_reg <= 8'h00;
         rem_reg <= 8'h00;
         frc_reg <= 1'b1;
      end else begin
         loc_reg <= loc_next;
         rem_reg <= rem_next;
         frc_reg <= frc_next;
      end
   end

   // sign/magnitude whole-degree correction, saturating so a hot reading never wraps cold
   function automatic logic signed [10:0] cf(input logic signed [10:0] t, input logic [7:0] c);
      logic signed [11:0] m;
      logic signed [11:0] s;
      m = $signed({5'h00, c[3:0], 3'h0});
      s = c[7] ? t - m : t + m;
      return (s > 12'sd1023) ? 11'sh3ff : ((s < -12'sd1024) ? 11'sh400 : s[10:0]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   fan_forced_a: assert property (alarm_drive_i && frc_reg |=> fan_full_speed_o && fan_duty_o == 4'hf)
      else $error("fan not forced to full speed");
   fan_normal_a: assert property (!(alarm_drive_i && frc_reg) |=> !fan_full_speed_o && fan_duty_o == $past(fan_duty_cmd_i))
      else $error("fan left its commanded speed");
   rev_read_a: assert property (reg_rd_i && reg_addr_i == 8'h3f |=> reg_rdata_o == {$past(frc_reg), 3'h0, 4'h1})
      else $error("override byte read wrong");
   loc_read_a: assert property (reg_rd_i && reg_addr_i == 8'h0d |=> reg_rdata_o == $past(loc_reg))
      else $error("local correction read wrong");
   rem_read_a: assert property (reg_rd_i && reg_addr_i == 8'h0e |=> reg_rdata_o == $past(rem_reg))
      else $error("remote correction read wrong");
   unmapped_read_a: assert property (reg_rd_i && !(reg_addr_i inside {8'h0d, 8'h0e, 8'h3f}) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   loc_corr_a: assert property (1'b1 |=> local_temp_corr_o == cf($past(local_temp_raw_i), $past(loc_reg)))
      else $error("local corrected reading wrong");
   rem_corr_a: assert property (1'b1 |=> remote_temp_corr_o == cf($past(remote_temp_raw_i), $past(rem_reg)))
      else $error("remote corrected reading wrong");
   // pin reaches the status flop three edges late, so only look once the synchroniser has refilled after reset
   ext_pull_a: assert property ($past(rst_n_i, 2) && $past(rst_n_i) |=>
      alarm_ext_pull_o == (!$past(alarm_pin_i, 3) && !$past(alarm_drive_i)))
      else $error("outside pull status wrong");
endmodule

bind tofo_regs tofo_checker tofo_checker_inst (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
   .reg_rd_i, .reg_rdata_o, .local_temp_raw_i, .remote_temp_raw_i, .local_temp_corr_o, .remote_temp_corr_o,
   .alarm_drive_i, .alarm_pin_i, .fan_duty_cmd_i, .fan_duty_o, .fan_full_speed_o, .alarm_ext_pull_o);

`default_nettype wire

/* verif/tofo_host_model.sv */
// Purpose: management host that reads and writes the register port one byte at a time
// Assumes: strobes are one-cycle pulses, read data is taken one cycle after the strobe
// Notes: idle address and data show the inverse of the last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module tofo_host_model (
   // clock and returned data
   input wire logic core_clk_i,
   input wire logic [7:0] reg_rdata_i,
   // request lines
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o
);
   // quiet port at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end

   // one write, launched and released at falling edges around the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(negedge core_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask

   // one read, data taken once the registered answer has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(negedge core_clk_i);
      d = reg_rdata_i;
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
   endtask
endmodule

`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench of the correction and override registers
// Assumes: host model drives the register port, the bench drives readings and alarm
// Notes: random traffic with a fixed seed, then directed fan and saturation cases
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr, wdata, rdata, d, loc, rem;
   logic wr, rd, drive = 1'b0, pin = 1'b1, frc, rnd = 1'b1, full, ext;
   logic signed [10:0] lraw = 11'sh000, rraw = 11'sh000, lcorr, rcorr;
   logic [3:0] cmd = 4'h0, duty;
   logic [7:0] tbl [4] = '{8'h0d, 8'h0e, 8'h3f, 8'h55};
   int n_mismatch = 0, checked = 0, seed = 32'h75e2;

   always #2.5 core_clk_i = ~core_clk_i;

   tofo_host_model tofo_host_model_inst (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
   tofo_regs tofo_regs_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .local_temp_raw_i(lraw), .remote_temp_raw_i(rraw),
      .local_temp_corr_o(lcorr), .remote_temp_corr_o(rcorr), .alarm_drive_i(drive), .alarm_pin_i(pin),
      .fan_duty_cmd_i(cmd), .fan_duty_o(duty), .fan_full_speed_o(full), .alarm_ext_pull_o(ext));

   // expected read data from the bench's own copy of the stored bytes
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         tofo_pkg::ADDR_LOCAL_CORR: return loc;
         tofo_pkg::ADDR_REMOTE_CORR: return rem;
         tofo_pkg::ADDR_OVR_REV: return {frc, 3'h0, tofo_pkg::SILICON_REVISION};
         default: return 8'h00;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // random readings and alarm traffic while the flag allows
   always @(negedge core_clk_i) begin
      if (rnd) begin
         lraw <= 11'($random(seed));
         rraw <= 11'($random(seed));
         drive <= 1'($random(seed));
         pin <= 1'($random(seed));
         cmd <= 4'($random(seed));
      end
   end

   // hang guard well above the length of the sequence
   initial begin
      #200000;
      n_mismatch++;
      summarize;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i) rst_n_i <= 1'b1;
      {loc, rem, frc} = {8'h00, 8'h00, 1'b1};
      foreach (tbl[i]) begin
         tofo_host_model_inst.rd(tbl[i], d);
         chk(d, exp_rd(tbl[i]));
      end
      // random writes, each read back at once
      repeat (60) begin
         addr_pick: begin
            logic [7:0] a, v;
            a = tbl[2'($random(seed))];
            v = 8'($random(seed));
            tofo_host_model_inst.wr(a, v);
            if (a == 8'h0d) loc = v;
            if (a == 8'h0e) rem = v;
            if (a == 8'h3f) frc = v[7];
            tofo_host_model_inst.rd(a, d);
            chk(d, exp_rd(a));
         end
      end
      rnd = 1'b0;
      tofo_host_model_inst.wr(8'h3f, 8'h80);
      @(negedge core_clk_i) {drive, pin, cmd} <= {1'b1, 1'b0, 4'h3};
      @(negedge core_clk_i) chk({full, duty}, {1'b1, 4'hf});
      chk(ext, 1'b0);
      tofo_host_model_inst.wr(8'h3f, 8'h7f);
      @(negedge core_clk_i) chk({full, duty}, {1'b0, 4'h3});
      tofo_host_model_inst.wr(8'h3f, 8'h80);
      @(negedge core_clk_i) drive <= 1'b0;
      repeat (4) @(negedge core_clk_i);
      chk({full, duty}, {1'b0, 4'h3});
      chk(ext, 1'b1);
      {lraw, rraw} = {11'sh140, 11'sh3fa};
      tofo_host_model_inst.wr(8'h0d, 8'h85);
      tofo_host_model_inst.wr(8'h0e, 8'h0f);
      @(negedge core_clk_i) chk(lcorr, 11'sh118);
      chk(rcorr, 11'sh3ff);
      rraw = 11'sh400;
      tofo_host_model_inst.wr(8'h0d, 8'h05);
      tofo_host_model_inst.wr(8'h0e, 8'h8f);
      @(negedge core_clk_i) chk(lcorr, 11'sh168);
      chk(rcorr, 11'sh400);
      // reset in mid-run must restore the power-up bytes
      rst_n_i = 1'b0;
      @(negedge core_clk_i) rst_n_i <= 1'b1;
      tofo_host_model_inst.rd(8'h0d, d);
      chk(d, 8'h00);
      tofo_host_model_inst.rd(8'h3f, d);
      chk(d, 8'h81);
      summarize;
   end
endmodule

`default_nettype wire
